// File: verilog/fcm_master.sv
// flash command master: sequences flash command writes, reached over AXI4-Lite
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "fcm_defs.svh"
module fcm_master
    import fcm_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 32,
    parameter logic [ADDR_W-1:0] UNLOCK1_ADDR = 20'h00555,
    parameter logic [7:0] UNLOCK1_DATA = 8'haa,
    parameter logic [ADDR_W-1:0] UNLOCK2_ADDR = 20'h002aa,
    parameter logic [7:0] UNLOCK2_DATA = 8'h55,
    parameter logic [7:0] CMD_RESET = 8'hf0,
    parameter logic [7:0] CMD_PROG_SETUP = 8'ha0,
    parameter logic [7:0] CMD_AUTOSELECT = 8'h90
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_chip_select_n,
    output logic flash_write_strobe_n,
    output logic flash_output_enable_n,
    output logic [DATA_W-1:0] flash_data_out,
    output logic flash_data_oe,
    input wire logic [DATA_W-1:0] flash_data_in,
    output logic flash_reset_n,
    output logic width_select,
    input wire logic ready_busy_n
);
    localparam logic [15:0] CYC_RST = 16'(`FCM_CYC_RST);
    typedef enum logic [2:0] {M_IDLE, M_CYCLE, M_WAIT, M_BUSY, M_HWRST} fcm_m_state_t;

    fcm_m_state_t state_q;
    fcm_mode_t mode_q;
    fcm_op_t op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic width_q;
    logic busy_q, err_q, prot_q;
    logic [2:0] step_q;
    logic [15:0] rst_cnt_q;
    logic go;
    logic [2:0] go_op;
    logic bc_start, bc_write, bc_done;
    logic [ADDR_W-1:0] bc_addr;
    logic [DATA_W-1:0] bc_wdata, bc_rdata;
    logic last_step;
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;

    // address and data taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FCM_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
            end
            if (aw_have_q && w_have_q)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q[7:2] > (`FCM_REG_MODE >> 2)) ? `FCM_RESP_SLVERR : `FCM_RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign go = aw_have_q && w_have_q && aw_addr_q == `FCM_REG_CTRL && w_data_q[`FCM_CTRL_GO_BIT];
    assign go_op = w_data_q[`FCM_CTRL_OP_LSB +: 3];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            addr_q <= '0;
            wdata_q <= '0;
            width_q <= 1'b1;
        end
        else if (aw_have_q && w_have_q && !busy_q)
        begin
            if (aw_addr_q == `FCM_REG_ADDR)
                addr_q <= w_data_q[ADDR_W-1:0];
            if (aw_addr_q == `FCM_REG_WDATA)
                wdata_q <= w_data_q[DATA_W-1:0];
            if (aw_addr_q == `FCM_REG_CTRL)
                width_q <= w_data_q[`FCM_CTRL_WIDTH_BIT];
        end
    end

    // AXI read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FCM_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FCM_RESP_OKAY;
            unique case (s_axi_araddr)
                `FCM_REG_CTRL: s_axi_rdata <= 32'({op_q, 1'b0} | (32'(width_q) << `FCM_CTRL_WIDTH_BIT));
                `FCM_REG_ADDR: s_axi_rdata <= 32'(addr_q);
                `FCM_REG_WDATA: s_axi_rdata <= 32'(wdata_q);
                `FCM_REG_STATUS: s_axi_rdata <= 32'({prot_q, err_q, busy_q});
                `FCM_REG_RDATA: s_axi_rdata <= 32'(rdata_q);
                `FCM_REG_MODE: s_axi_rdata <= 32'(mode_q);
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `FCM_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // one bus cycle per step of the selected sequence
    always_comb
    begin
        bc_write = 1'b1;
        bc_addr = addr_q;
        bc_wdata = wdata_q;
        last_step = 1'b1;
        unique case (op_q)
            FCM_OP_RESET:
                bc_wdata = DATA_W'(CMD_RESET);
            FCM_OP_READ:
            begin
                bc_write = 1'b0;
                // offset by width
                if (mode_q == FCM_MODE_AUTOSELECT)
                    bc_addr = {addr_q[ADDR_W-1:8], width_q ? `FCM_PROT_OFS_WORD : `FCM_PROT_OFS_BYTE};
            end
            FCM_OP_PROGRAM, FCM_OP_BYPASS_ENTER, FCM_OP_AUTOSELECT:
            begin
                // two unlocks then the command code; program adds a fourth step writing wdata_q to addr_q
                last_step = (step_q == 3'd3) || (op_q != FCM_OP_PROGRAM && step_q == 3'd2);
                unique case (step_q)
                    3'd0:
                    begin
                        bc_addr = UNLOCK1_ADDR;
                        bc_wdata = DATA_W'(UNLOCK1_DATA);
                    end
                    3'd1:
                    begin
                        bc_addr = UNLOCK2_ADDR;
                        bc_wdata = DATA_W'(UNLOCK2_DATA);
                    end
                    3'd2:
                    begin
                        bc_addr = UNLOCK1_ADDR;
                        bc_wdata = op_q == FCM_OP_PROGRAM ? DATA_W'(CMD_PROG_SETUP) :
                            op_q == FCM_OP_AUTOSELECT ? DATA_W'(CMD_AUTOSELECT) : DATA_W'(`FCM_CMD_BYPASS);
                    end
                    default: ;
                endcase
            end
            FCM_OP_BYPASS_PROGRAM:
            begin
                last_step = step_q == 3'd1;
                if (step_q == 3'd0)
                    bc_wdata = DATA_W'(`FCM_CMD_BYPASS_PROG);
            end
            FCM_OP_BYPASS_EXIT:
            begin
                last_step = step_q == 3'd1;
                bc_wdata = step_q == 3'd0 ? DATA_W'(`FCM_CMD_BYPASS_EXIT1) : DATA_W'(`FCM_CMD_BYPASS_EXIT2);
            end
            FCM_OP_HW_RESET: ;
        endcase
    end

    assign bc_start = state_q == M_CYCLE;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= M_IDLE;
            op_q <= FCM_OP_RESET;
            step_q <= 3'd0;
            busy_q <= 1'b0;
            rst_cnt_q <= 16'h0;
        end
        else
        begin
            unique case (state_q)
                M_IDLE:
                begin
                    if (go)
                    begin
                        op_q <= fcm_op_t'(go_op);
                        step_q <= 3'd0;
                        busy_q <= 1'b1;
                        rst_cnt_q <= CYC_RST;
                        state_q <= fcm_op_t'(go_op) == FCM_OP_HW_RESET ? M_HWRST : M_CYCLE;
                    end
                end
                M_CYCLE:
                    state_q <= M_WAIT;
                M_WAIT:
                begin
                    if (bc_done)
                    begin
                        step_q <= step_q + 3'd1;
                        // wait out the algorithm; writes meanwhile would be ignored
                        if (last_step && (op_q == FCM_OP_PROGRAM || op_q == FCM_OP_BYPASS_PROGRAM))
                            state_q <= M_BUSY;
                        else if (last_step)
                        begin
                            busy_q <= 1'b0;
                            state_q <= M_IDLE;
                        end
                        else
                            state_q <= M_CYCLE;
                    end
                end
                M_BUSY:
                begin
                    if (ready_busy_n)
                    begin
                        busy_q <= 1'b0;
                        state_q <= M_IDLE;
                    end
                end
                M_HWRST:
                begin
                    // long enough to abort
                    if (rst_cnt_q <= 16'h1)
                    begin
                        busy_q <= 1'b0;
                        state_q <= M_IDLE;
                    end
                    else
                        rst_cnt_q <= rst_cnt_q - 16'h1;
                end
            endcase
        end
    end

    // device mode shadow
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_q == M_HWRST)
            mode_q <= FCM_MODE_ARRAY;
        else if (state_q == M_WAIT && bc_done && last_step)
        begin
            unique case (op_q)
                FCM_OP_RESET: if (mode_q != FCM_MODE_BYPASS) mode_q <= FCM_MODE_ARRAY;
                FCM_OP_AUTOSELECT: mode_q <= FCM_MODE_AUTOSELECT;
                FCM_OP_BYPASS_ENTER: mode_q <= FCM_MODE_BYPASS;
                FCM_OP_BYPASS_EXIT: mode_q <= FCM_MODE_ARRAY;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_q <= '0;
            err_q <= 1'b0;
            prot_q <= 1'b0;
        end
        else
        begin
            if (state_q == M_WAIT && bc_done && op_q == FCM_OP_READ)
            begin
                rdata_q <= bc_rdata;
                prot_q <= mode_q == FCM_MODE_AUTOSELECT && bc_rdata[7:0] == `FCM_PROT_YES;
            end
            if (state_q == M_IDLE && go)
                err_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
        flash_reset_n <= aresetn && state_q != M_HWRST;

    assign width_select = width_q;

    fcm_bus_cycle #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_cycle (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(bc_start),
        .is_write(bc_write),
        .addr(bc_addr),
        .wdata(bc_wdata),
        .done(bc_done),
        .rdata(bc_rdata),
        .flash_addr(flash_addr),
        .flash_chip_select_n(flash_chip_select_n),
        .flash_write_strobe_n(flash_write_strobe_n),
        .flash_output_enable_n(flash_output_enable_n),
        .flash_data_out(flash_data_out),
        .flash_data_oe(flash_data_oe),
        .flash_data_in(flash_data_in)
    );
endmodule // fcm_master

// File: pkg/fcm_defs.svh
// timing counts, command codes and register offsets for the flash command master
`ifndef FCM_DEFS_SVH
`define FCM_DEFS_SVH
`define FCM_CLK_MHZ 20
`define FCM_T_SETUP_NS 50
`define FCM_T_PULSE_NS 100
`define FCM_T_HOLD_NS 50
`define FCM_T_READ_NS 150
`define FCM_T_RST_NS 500
`define FCM_CYC_SETUP ((`FCM_T_SETUP_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_CYC_PULSE ((`FCM_T_PULSE_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_CYC_HOLD ((`FCM_T_HOLD_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_CYC_READ ((`FCM_T_READ_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_CYC_RST ((`FCM_T_RST_NS * `FCM_CLK_MHZ + 999) / 1000)
`define FCM_CMD_BYPASS 8'h20
`define FCM_CMD_BYPASS_PROG 8'ha0
`define FCM_CMD_BYPASS_EXIT1 8'h90
`define FCM_CMD_BYPASS_EXIT2 8'h00
`define FCM_PROT_OFS_WORD 8'h02
`define FCM_PROT_OFS_BYTE 8'h04
`define FCM_PROT_YES 8'h02
`define FCM_REG_CTRL 8'h00
`define FCM_REG_ADDR 8'h04
`define FCM_REG_WDATA 8'h08
`define FCM_REG_STATUS 8'h0c
`define FCM_REG_RDATA 8'h10
`define FCM_REG_MODE 8'h14
`define FCM_CTRL_GO_BIT 0
`define FCM_CTRL_OP_LSB 1
`define FCM_CTRL_WIDTH_BIT 4
`define FCM_ST_BUSY_BIT 0
`define FCM_ST_ERR_BIT 1
`define FCM_ST_PROT_BIT 2
`define FCM_RESP_OKAY 2'b00
`define FCM_RESP_SLVERR 2'b10
`endif

// File: pkg/fcm_pkg.sv
// types for the flash command master
package fcm_pkg;
    typedef enum logic [2:0] {
        FCM_OP_RESET,
        FCM_OP_READ,
        FCM_OP_PROGRAM,
        FCM_OP_BYPASS_ENTER,
        FCM_OP_BYPASS_PROGRAM,
        FCM_OP_BYPASS_EXIT,
        FCM_OP_AUTOSELECT,
        FCM_OP_HW_RESET
    } fcm_op_t;
    typedef enum logic [1:0] {
        FCM_MODE_ARRAY,
        FCM_MODE_AUTOSELECT,
        FCM_MODE_BYPASS
    } fcm_mode_t;
endpackage

// File: verilog/fcm_bus_cycle.sv
// one flash bus cycle: write strobe pulse or output-enable read
`timescale 1ns/1ps
`include "fcm_defs.svh"
module fcm_bus_cycle
    import fcm_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 32
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_chip_select_n,
    output logic flash_write_strobe_n,
    output logic flash_output_enable_n,
    output logic [DATA_W-1:0] flash_data_out,
    output logic flash_data_oe,
    input wire logic [DATA_W-1:0] flash_data_in
);
    typedef enum logic [2:0] {BC_IDLE, BC_SETUP, BC_PULSE, BC_HOLD, BC_READ} fcm_bc_state_t;
    localparam logic [7:0] CYC_SETUP = 8'(`FCM_CYC_SETUP);
    localparam logic [7:0] CYC_PULSE = 8'(`FCM_CYC_PULSE);
    localparam logic [7:0] CYC_HOLD = 8'(`FCM_CYC_HOLD);
    localparam logic [7:0] CYC_READ = 8'(`FCM_CYC_READ);
    fcm_bc_state_t state_q;
    logic [7:0] cnt_q;
    logic wr_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= BC_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            cnt_q <= cnt_q - 8'h01;
            unique case (state_q)
                BC_IDLE:
                begin
                    if (start)
                    begin
                        wr_q <= is_write;
                        cnt_q <= CYC_SETUP;
                        state_q <= BC_SETUP;
                    end
                end
                BC_SETUP:
                begin
                    // address settles before the later falling strobe edge
                    if (cnt_q <= 8'h01)
                    begin
                        cnt_q <= wr_q ? CYC_PULSE : CYC_READ;
                        state_q <= wr_q ? BC_PULSE : BC_READ;
                    end
                end
                BC_PULSE, BC_READ:
                begin
                    if (cnt_q <= 8'h01)
                    begin
                        cnt_q <= CYC_HOLD;
                        state_q <= BC_HOLD;
                    end
                end
                BC_HOLD:
                begin
                    if (cnt_q <= 8'h01)
                    begin
                        done <= 1'b1;
                        state_q <= BC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flash_addr <= '0;
            flash_data_out <= '0;
            rdata <= '0;
        end
        else
        begin
            if (state_q == BC_IDLE && start)
            begin
                flash_addr <= addr;
                flash_data_out <= wdata;
            end
            if (state_q == BC_READ && cnt_q <= 8'h01)
                rdata <= flash_data_in;
        end
    end

    // write = select and strobe low with output enable high
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flash_chip_select_n <= 1'b1;
            flash_write_strobe_n <= 1'b1;
            flash_output_enable_n <= 1'b1;
            flash_data_oe <= 1'b0;
        end
        else
        begin
            flash_chip_select_n <= !(state_q == BC_SETUP || state_q == BC_PULSE || state_q == BC_READ ||
                (state_q == BC_IDLE && start));
            // data held through the strobe rising edge, released after hold
            flash_write_strobe_n <= !(state_q == BC_SETUP && wr_q && cnt_q <= 8'h01) &&
                !(state_q == BC_PULSE && cnt_q > 8'h01);
            flash_output_enable_n <= !((state_q == BC_SETUP && !wr_q && cnt_q <= 8'h01) ||
                (state_q == BC_READ && cnt_q > 8'h01));
            flash_data_oe <= (state_q == BC_IDLE && start && is_write) ||
                (wr_q && (state_q == BC_SETUP || state_q == BC_PULSE ||
                (state_q == BC_HOLD && cnt_q > 8'h01)));
        end
    end
endmodule // fcm_bus_cycle

// File: tb/fcm_master_checker.sv
// pin-level assertions for the flash command master
`timescale 1ns/1ps
module fcm_master_checker #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 32
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic flash_chip_select_n,
    input wire logic flash_write_strobe_n,
    input wire logic flash_output_enable_n,
    input wire logic [DATA_W-1:0] flash_data_out,
    input wire logic flash_reset_n,
    input wire logic ready_busy_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_frame; !flash_write_strobe_n |-> !flash_chip_select_n && flash_output_enable_n; endproperty
    a_frame: assert property (p_frame) else $error("strobe outside frame");
    property p_inhibit; !flash_output_enable_n |-> flash_write_strobe_n; endproperty
    a_inhibit: assert property (p_inhibit) else $error("strobe during read");
    property p_pulse; $fell(flash_write_strobe_n) |=> !flash_write_strobe_n ##1 flash_write_strobe_n; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe width");
    // address latched at the later fall
    property p_setup; $fell(flash_write_strobe_n) |-> $past(!flash_chip_select_n); endproperty
    a_setup: assert property (p_setup) else $error("select setup");
    property p_hold; $rose(flash_write_strobe_n) |-> !flash_chip_select_n; endproperty
    a_hold: assert property (p_hold) else $error("select hold");
    property p_stable; !flash_write_strobe_n && $past(!flash_write_strobe_n) |-> $stable(flash_addr) && $stable(flash_data_out); endproperty
    a_stable: assert property (p_stable) else $error("bus moved in pulse");
    property p_busy; $fell(flash_write_strobe_n) |-> ready_busy_n; endproperty
    a_busy: assert property (p_busy) else $error("write while busy");
    property p_rst; $fell(flash_reset_n) |-> !flash_reset_n[*8]; endproperty
    a_rst: assert property (p_rst) else $error("reset pulse short");
endmodule // fcm_master_checker
bind fcm_master fcm_master_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_fcm_master_checker (.aclk, .aresetn,
    .flash_addr, .flash_chip_select_n, .flash_write_strobe_n, .flash_output_enable_n, .flash_data_out, .flash_reset_n,
    .ready_busy_n);

// File: tb/fcm_flash_model.sv
// behavioural flash part: command decoder, array, protection query
`timescale 1ns/1ps
module fcm_flash_model #(
    parameter logic [3:0] PROT_SEC = 4'h3
)(
    input wire logic [19:0] flash_addr,
    input wire logic flash_chip_select_n,
    input wire logic flash_write_strobe_n,
    input wire logic flash_output_enable_n,
    input wire logic [31:0] flash_data_out,
    input wire logic flash_reset_n,
    input wire logic width_select,
    output logic [31:0] flash_data_in = 32'h0,
    output logic ready_busy_n = 1'b1
);
    logic [31:0] mem_q [logic [19:0]];
    logic [19:0] a_q;
    logic [7:0] d;
    int step_q = 0;
    // 0 array, 1 autoselect, 2 bypass
    int mode_q = 0;
    always @(negedge flash_write_strobe_n) a_q = flash_addr;
    always @(negedge flash_reset_n)
    begin
        step_q = 0;
        mode_q = 0;
        ready_busy_n = 1'b1;
    end
    always @(posedge flash_write_strobe_n)
    begin
        d = flash_data_out[7:0];
        if (!flash_chip_select_n && flash_output_enable_n && flash_reset_n && ready_busy_n)
        begin
            if (step_q == 3)
            begin
                mem_q[a_q] = (mem_q.exists(a_q) ? mem_q[a_q] : 32'hffffffff) & flash_data_out;
                ready_busy_n = 1'b0;
                // busy time varies with the data so both quick and slow answers occur
                ready_busy_n <= #(100 + 40 * d[2:0]) 1'b1;
                step_q = 0;
            end
            else if (mode_q == 2)
            begin
                if (step_q == 6 && d == 8'h00) mode_q = 0;
                step_q = step_q == 0 && d == 8'ha0 ? 3 : step_q == 0 && d == 8'h90 ? 6 : 0;
            end
            else if (step_q == 0 && a_q == 20'h00555 && d == 8'haa)
                step_q = 1;
            else if (step_q == 1 && a_q == 20'h002aa && d == 8'h55)
                step_q = 2;
            else if (step_q == 2 && d == 8'ha0)
                step_q = 3;
            else
            begin
                mode_q = d == 8'hf0 ? 0 : step_q != 2 ? mode_q : d == 8'h90 ? 1 : d == 8'h20 ? 2 : mode_q;
                step_q = 0;
            end
        end
    end
    // released bus shows the inverse of the last word, never a stale copy
    always @(posedge flash_output_enable_n) flash_data_in = ~flash_data_in;
    always @(negedge flash_output_enable_n)
        if (mode_q == 1)
            flash_data_in = flash_addr[7:0] != (width_select ? 8'h02 : 8'h04) ? 32'h0 :
                flash_addr[19:16] == PROT_SEC ? 32'h2 : 32'h0;
        else
            flash_data_in = mem_q.exists(flash_addr) ? mem_q[flash_addr] : 32'hffffffff;
endmodule // fcm_flash_model

// File: tb/fcm_master_tb.sv
// self-checking bench for the flash command master
`timescale 1ns/1ps
`include "fcm_defs.svh"
module fcm_master_tb
    import fcm_pkg::*;
;
    localparam logic [3:0] PROT_SEC = 4'h3;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, flash_chip_select_n;
    logic flash_write_strobe_n, flash_output_enable_n, flash_data_oe, flash_reset_n, width_select, ready_busy_n;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, flash_data_out, flash_data_in;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [19:0] flash_addr;
    logic [31:0] ref_mem [logic [19:0]];
    int error_cnt = 0, tests_run = 0, cyc = 0, tn = 0;
    fcm_master i_fcm_master (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_chip_select_n,
        .flash_write_strobe_n, .flash_output_enable_n, .flash_data_out, .flash_data_oe, .flash_data_in, .flash_reset_n,
        .width_select, .ready_busy_n);
    fcm_flash_model #(.PROT_SEC(PROT_SEC)) i_fcm_flash_model (.flash_addr, .flash_chip_select_n, .flash_write_strobe_n,
        .flash_output_enable_n, .flash_data_out, .flash_reset_n, .width_select, .flash_data_in, .ready_busy_n);
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            error_cnt++;
            end_sim();
        end
    end
    function automatic logic [31:0] exp_rd(input logic [19:0] a);
        return ref_mem.exists(a) ? ref_mem[a] : 32'hffffffff;
    endfunction
    function automatic logic [31:0] exp_prot(input logic [19:0] a);
        return a[19:16] == PROT_SEC ? 32'h2 : 32'h0;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // idle channel keeps valid low
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        q = s_axi_rdata;
        r = wr ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 0;
        s_axi_rready <= 0;
    endtask
    task automatic op(input fcm_op_t o, input logic w, input logic [19:0] a, input logic [31:0] d, output logic [31:0] q);
        logic [1:0] r;
        axi(1, `FCM_REG_ADDR, {12'h0, a}, q, r);
        axi(1, `FCM_REG_WDATA, d, q, r);
        axi(1, `FCM_REG_CTRL, {27'h0, w, o, 1'b1}, q, r);
        do axi(0, `FCM_REG_STATUS, 0, q, r); while (q[`FCM_ST_BUSY_BIT] !== 1'b0);
        axi(0, `FCM_REG_RDATA, 0, q, r);
    endtask
    task automatic mode_now(output logic [31:0] v);
        logic [1:0] r;
        axi(0, `FCM_REG_MODE, 0, v, r);
    endtask
    task automatic tdone();
        tn++;
        $display("test %0d done", tn);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        logic [31:0] v;
        logic [31:0] x;
        logic [19:0] a;
        logic [1:0] r;
        v = $urandom(12);
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        mode_now(v);
        chk(v, 32'h0);
        axi(0, 8'h40, 0, v, r);
        chk(32'(r), 32'(`FCM_RESP_SLVERR));
        tdone();
        // odd passes reprogram the same word
        for (int i = 0; i < 6; i++)
        begin
            a = i == 0 ? 20'h00555 : i[0] ? a : 20'($urandom);
            v = $urandom;
            op(FCM_OP_PROGRAM, 1, a, v, x);
            ref_mem[a] = exp_rd(a) & v;
            op(FCM_OP_READ, 1, a, 0, x);
            chk(x, exp_rd(a));
        end
        tdone();
        for (int i = 0; i < 4; i++)
        begin
            a = {i[1] ? PROT_SEC : 4'h9, 16'($urandom)};
            op(FCM_OP_AUTOSELECT, i[0], 0, 0, x);
            mode_now(v);
            chk(v, 32'h1);
            op(FCM_OP_READ, i[0], a, 0, x);
            chk({24'h0, x[7:0]}, exp_prot(a));
            op(FCM_OP_RESET, 1, 0, 0, x);
            op(FCM_OP_READ, 1, 20'h00555, 0, x);
            chk(x, exp_rd(20'h00555));
        end
        tdone();
        op(FCM_OP_BYPASS_ENTER, 1, 0, 0, x);
        for (int i = 0; i < 3; i++)
        begin
            mode_now(v);
            chk(v, 32'h2);
            a = 20'($urandom);
            v = $urandom;
            op(FCM_OP_BYPASS_PROGRAM, 1, a, v, x);
            ref_mem[a] = exp_rd(a) & v;
            op(FCM_OP_READ, 1, a, 0, x);
            chk(x, exp_rd(a));
            op(FCM_OP_RESET, 1, 0, 0, x);
        end
        op(FCM_OP_BYPASS_EXIT, 1, 0, 0, x);
        mode_now(v);
        chk(v, 32'h0);
        tdone();
        op(FCM_OP_AUTOSELECT, 1, 0, 0, x);
        op(FCM_OP_HW_RESET, 1, 0, 0, x);
        mode_now(v);
        chk(v, 32'h0);
        op(FCM_OP_READ, 1, a, 0, x);
        chk(x, exp_rd(a));
        tdone();
        end_sim();
    end
endmodule // fcm_master_tb
